// File: fpi_interrupt_unit.sv
`timescale 1ns/10ps
`default_nettype none
module fpi_interrupt_unit (
   // Clock and reset
   input  wire logic                clk_sys,
   input  wire logic                nrst,
   // Data space write port from core
   input  wire logic                dataWrite,     // Byte write strobe
   input  wire logic                bitOp,         // Single-bit operation
   input  wire logic [7:0]          dataAddr,      // Data address
   input  wire logic [7:0]          dataWdata,     // Write data
   // Core sequencing
   input  wire logic                lastCycle,     // Final cycle of instruction
   input  wire logic                retiExec,      // return_from_interrupt executing
   // Pins
   input  wire logic                infrared_pin,  // Infrared input
   input  wire logic                vsync_pin,     // Vertical sync pin
   input  wire logic                power_pin,     // Power input
   // Latch controls for infrared and power
   input  wire logic                irRiseSel,     // Infrared latch on rising edge
   input  wire logic                irEnable,      // Infrared latch enabled
   input  wire logic                irClear,       // Software clear infrared latch
   input  wire logic                pwrRiseSel,    // Power latch on rising edge
   input  wire logic                pwrEnable,     // Power latch enabled
   input  wire logic                pwrClear,      // Software clear power latch
   input  wire logic                vsyncEnable,   // Vertical sync enabled
   // Timers
   input  wire logic                tmr1_flag,     // timer_request_flag, first timer
   input  wire logic                tmr1_mask,     // timer_request_mask, first timer
   input  wire logic                tmr2_flag,     // timer_request_flag, second timer
   input  wire logic                tmr2_mask,     // timer_request_mask, second timer
   // To core
   output fpi_pkg::fpi_entry_t      entry,         // Entry/return handshake
   output fpi_pkg::fpi_flagset_t    flagSet,       // Active C/Z set
   output logic                     infraredLatch, // Readable infrared latch
   output logic                     infrared_request,
   output logic                     power_request
);
   // Option register fields
   logic [7:0] opt_q;                                       // interrupt_option
   wire  vec1_level_select  = opt_q[fpi_pkg::OPT_LEVEL1_BIT];
   wire  vec2_edge_polarity = opt_q[fpi_pkg::OPT_EDGE2_BIT];
   wire  global_irq_enable  = opt_q[fpi_pkg::OPT_GEN_BIT];

   // Byte writes only; bit operations do not reach it
   wire optWr = dataWrite & ~bitOp & (dataAddr == fpi_pkg::INTERRUPT_OPTION_ADDR);

   always_ff @(posedge clk_sys) begin
      if (!nrst)
         opt_q <= fpi_pkg::OPT_RESET;
      else if (optWr)
         opt_q <= dataWrite ? (dataWdata & 8'h70) : opt_q;
   end

   // Mode state: flag set in use and saved set for return
   fpi_pkg::fpi_flagset_t mode_q, mode_d;
   fpi_pkg::fpi_flagset_t saved_q, saved_d;
   logic [2:0] src_d;
   logic       take_d;
   logic [11:0] vec_d;

   // Clear pulses on acknowledge for NMI, vector one and vector two only
   wire ackNmi  = take_d & (src_d == 3'h0);
   wire ackVec1 = take_d & (src_d == 3'h1);
   wire ackVec2 = take_d & (src_d == 3'h2);

   // Infrared pin latch; request inverts it, high when disabled
   logic irLat;
   fpi_edge_latch uIr (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .sigIn   (infrared_pin),
      .onRise  (irEnable & irRiseSel),
      .onFall  (irEnable & ~irRiseSel),
      .clrIn   (irClear | ~irEnable),
      .latched (irLat)
   );
   assign infraredLatch    = irLat;
   assign infrared_request = ~irLat;

   // NMI edge: falling request edge, cleared only by service
   logic nmiPend;
   fpi_edge_latch uNmi (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .sigIn   (infrared_request),
      .onRise  (1'b0),
      .onFall  (1'b1),
      .clrIn   (ackNmi),
      .latched (nmiPend)
   );

   // Vsync: internal request inverts pin, low when disabled
   wire vsyncInt = vsyncEnable & ~vsync_pin;
   logic vsPend;
   fpi_edge_latch uVs (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .sigIn   (vsyncInt),
      .onRise  (~vec2_edge_polarity),
      .onFall  (vec2_edge_polarity),
      .clrIn   (ackVec2),
      .latched (vsPend)
   );

   // Power latch; request low while latched
   logic pwrLat;
   fpi_edge_latch uPwr (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .sigIn   (power_pin),
      .onRise  (pwrEnable & pwrRiseSel),
      .onFall  (pwrEnable & ~pwrRiseSel),
      .clrIn   (pwrClear | ~pwrEnable),
      .latched (pwrLat)
   );
   assign power_request = ~pwrLat;

   // Timer requests as low-active lines
   wire t2Req = ~(tmr2_flag & tmr2_mask);
   wire t1Req = ~(tmr1_flag & tmr1_mask);

   // Vector one edge mode: falling edge of timer line
   logic v1Edge;
   fpi_edge_latch uV1 (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .sigIn   (t2Req),
      .onRise  (1'b0),
      .onFall  (~vec1_level_select),
      .clrIn   (ackVec1 | vec1_level_select),
      .latched (v1Edge)
   );

   // Pending maskable lines, edge latches survive global disable
   wire [fpi_pkg::NUM_MASKABLE-1:0] pend;
   assign pend[0] = vec1_level_select ? ~t2Req : v1Edge;
   assign pend[1] = vsPend;
   assign pend[2] = ~t1Req;
   assign pend[3] = ~power_request;

   // Maskable allowed only in normal mode with global enable
   wire maskOk = global_irq_enable & (mode_q == fpi_pkg::FS_NORMAL);
   // After a return the next mode is what counts for sampling
   wire maskOkRet = global_irq_enable & (saved_q == fpi_pkg::FS_NORMAL);
   wire maskGate  = retiExec ? maskOkRet : maskOk;
   // NMI never nests in itself; allowed outside NMI mode
   wire nmiOk = (mode_q != fpi_pkg::FS_NMI) | retiExec;

   // Selection and mode update
   always_comb begin
      mode_d  = mode_q;
      saved_d = saved_q;
      take_d  = 1'b0;
      src_d   = 3'h0;
      vec_d   = fpi_pkg::VEC0_ADDR;
      if (lastCycle) begin
         // Return first restores previous set
         if (retiExec) begin
            mode_d  = saved_q;
            saved_d = fpi_pkg::FS_NORMAL;
         end
         if (nmiPend && nmiOk) begin
            take_d  = 1'b1;
            src_d   = 3'h0;
            vec_d   = fpi_pkg::VEC0_ADDR;
            // A return in the same cycle hands its restored set to the NMI
            saved_d = retiExec ? saved_q : mode_q;
            mode_d  = fpi_pkg::FS_NMI;
         end else if (maskGate && (pend != 4'h0)) begin
            take_d = 1'b1;
            // Fixed order, lowest number wins
            if (pend[0]) begin
               src_d = 3'h1;
               vec_d = fpi_pkg::VEC1_ADDR;
            end else if (pend[1]) begin
               src_d = 3'h2;
               vec_d = fpi_pkg::VEC2_ADDR;
            end else if (pend[2]) begin
               src_d = 3'h3;
               vec_d = fpi_pkg::VEC3_ADDR;
            end else begin
               src_d = 3'h4;
               vec_d = fpi_pkg::VEC4_ADDR;
            end
            saved_d = fpi_pkg::FS_NORMAL;
            mode_d  = fpi_pkg::FS_IRQ;
         end
      end
   end

   // Reset enters NMI mode until first return
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         mode_q  <= fpi_pkg::FS_NMI;
         saved_q <= fpi_pkg::FS_NORMAL;
      end else begin
         mode_q  <= mode_d;
         saved_q <= saved_d;
      end
   end

   // Vector, source and pulse share one cycle, combinational handshake
   // One driver for the whole bundle: take, vector, source, pop
   assign entry = {take_d, vec_d, src_d, lastCycle & retiExec};
   assign flagSet      = mode_q;

   // Checks
   chk_reset_nmi_mode: assert property (@(posedge clk_sys)
      $rose(nrst) |-> mode_q == fpi_pkg::FS_NMI)
      else $error("not in NMI mode after reset");
   chk_only_last_cycle: assert property (@(posedge clk_sys) disable iff (!nrst)
      entry.take |-> lastCycle)
      else $error("entry outside last cycle");
   chk_nmi_vector: assert property (@(posedge clk_sys) disable iff (!nrst)
      entry.take && entry.source == 3'h0 |-> entry.vector == 12'hffc)
      else $error("wrong NMI vector");
   chk_nmi_first: assert property (@(posedge clk_sys) disable iff (!nrst)
      lastCycle && nmiPend && nmiOk |-> entry.take && entry.source == 3'h0)
      else $error("NMI not taken");
   chk_no_nesting: assert property (@(posedge clk_sys) disable iff (!nrst)
      mode_q != fpi_pkg::FS_NORMAL && !retiExec && entry.take |-> entry.source == 3'h0)
      else $error("maskable nested");
   chk_prio_vec1: assert property (@(posedge clk_sys) disable iff (!nrst)
      entry.take && entry.source != 3'h0 && pend[0] |-> entry.vector == 12'hff6)
      else $error("priority broken");
   chk_gen_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
      !global_irq_enable && entry.take |-> entry.source == 3'h0)
      else $error("maskable while disabled");
   chk_entry_mode: assert property (@(posedge clk_sys) disable iff (!nrst)
      entry.take && entry.source != 3'h0 |=> flagSet == fpi_pkg::FS_IRQ)
      else $error("flag set not swapped");
   chk_nmi_sticky: assert property (@(posedge clk_sys) disable iff (!nrst)
      nmiPend && !ackNmi |=> nmiPend)
      else $error("NMI latch lost");
   chk_vs_sticky: assert property (@(posedge clk_sys) disable iff (!nrst)
      vsPend && !ackVec2 |=> vsPend)
      else $error("vsync latch lost");
   chk_opt_write: assert property (@(posedge clk_sys) disable iff (!nrst)
      optWr |=> opt_q == ($past(dataWdata) & 8'h70))
      else $error("option write wrong");
   chk_return_pop: assert property (@(posedge clk_sys) disable iff (!nrst)
      lastCycle && retiExec && !entry.take |=> flagSet == $past(saved_q))
      else $error("return did not restore");
   cov_nmi_entry: cover property (@(posedge clk_sys) entry.take && entry.source == 3'h0);
   cov_vec4_entry: cover property (@(posedge clk_sys) entry.take && entry.source == 3'h4);
   cov_ret_then_irq: cover property (@(posedge clk_sys) retiExec && entry.take);
endmodule : fpi_interrupt_unit
`default_nettype wire

// File: fpi_pkg.sv
package fpi_pkg;
   // Register map
   localparam logic [7:0]  INTERRUPT_OPTION_ADDR = 8'hc8;   // Write-only option register
   localparam int          OPT_LEVEL1_BIT        = 6;       // vec1_level_select
   localparam int          OPT_EDGE2_BIT         = 5;       // vec2_edge_polarity
   localparam int          OPT_GEN_BIT           = 4;       // global_irq_enable
   localparam logic [7:0]  OPT_RESET             = 8'h00;   // All option bits clear
   // Vector addresses (program space)
   localparam logic [11:0] VEC0_ADDR             = 12'hffc; // Non-maskable
   localparam logic [11:0] VEC1_ADDR             = 12'hff6; // Second timer
   localparam logic [11:0] VEC2_ADDR             = 12'hff4; // Vertical sync
   localparam logic [11:0] VEC3_ADDR             = 12'hff2; // First timer
   localparam logic [11:0] VEC4_ADDR             = 12'hff0; // Power pin
   localparam int          NUM_MASKABLE          = 4;       // Maskable sources

   // Flag set currently in use by the core
   typedef enum logic [1:0] {
      FS_NORMAL,
      FS_IRQ,
      FS_NMI
   } fpi_flagset_t;

   // Core handshake bundle toward the core
   typedef struct packed {
      logic        take;      // Entry cycle: load vector, push PC
      logic [11:0] vector;    // Vector address
      logic [2:0]  source;    // 0 = NMI, 1..4 maskable
      logic        popPc;     // Return: pop saved PC
   } fpi_entry_t;
endpackage : fpi_pkg

// File: fpi_edge_latch.sv
`timescale 1ns/10ps
`default_nettype none
// Sticky edge catcher: set on selected edge, cleared by service or software
module fpi_edge_latch (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic nrst,
   // Source
   input  wire logic sigIn,       // Sampled input level
   input  wire logic onRise,      // Catch rising edges
   input  wire logic onFall,      // Catch falling edges
   // Clearing
   input  wire logic clrIn,       // Service or software clear
   // Result
   output logic      latched     // Sticky flag
);
   logic prev_q;                  // Previous sample
   logic flag_q;                  // Sticky state
   wire  hit = (onRise & sigIn & ~prev_q) | (onFall & ~sigIn & prev_q);

   // Set wins over clear so an edge in the clearing cycle survives
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         prev_q <= 1'b0;
         flag_q <= 1'b0;
      end else begin
         prev_q <= sigIn;
         flag_q <= hit | (flag_q & ~clrIn);
      end
   end
   assign latched = flag_q;
endmodule : fpi_edge_latch
`default_nettype wire

// File: fpi_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// Core stand-in: fixed four-cycle instructions, return on request
module fpi_core_model (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic nrst,
   // Test control
   input  wire logic retiReq,    // Next instructions are returns
   // Toward the unit
   output logic      lastCycle,  // Final cycle of each instruction
   output logic      retiExec    // Return instruction running
);
   logic [1:0] phase_q;          // Byte cycle within instruction

   // Free-running cycle count; a real core never stalls mid-instruction
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end

   // Requests may only be sampled here, once per instruction
   assign lastCycle = (phase_q == 2'h3);
   // Follows retiReq directly, whatever the instruction phase
   assign retiExec  = retiReq;
endmodule : fpi_core_model
`default_nettype wire

// File: test_fixed_priority_interrupt_unit.sv
`timescale 1ns/10ps
`default_nettype none
module test_fixed_priority_interrupt_unit;
   logic                  clk_sys, nrst, dataWrite, bitOp, lastCycle;
   logic                  retiExec, retiReq, infrared_pin, vsync_pin, power_pin;
   logic                  irRiseSel, irEnable, irClear, pwrRiseSel, pwrEnable;
   logic                  pwrClear, vsyncEnable, tmr1_flag, tmr1_mask;
   logic                  tmr2_flag, tmr2_mask, infraredLatch;
   logic                  infrared_request, power_request;
   logic [7:0]            dataAddr, dataWdata;
   fpi_pkg::fpi_entry_t   entry;      // Entry and return strobes
   fpi_pkg::fpi_flagset_t flagSet;    // Active flag set
   int                    err_total, comparisons;
   localparam logic [7:0] OPT = fpi_pkg::INTERRUPT_OPTION_ADDR;

   fpi_interrupt_unit u_dut (
      .clk_sys          (clk_sys),
      .nrst             (nrst),
      .dataWrite        (dataWrite),
      .bitOp            (bitOp),
      .dataAddr         (dataAddr),
      .dataWdata        (dataWdata),
      .lastCycle        (lastCycle),
      .retiExec         (retiExec),
      .infrared_pin     (infrared_pin),
      .vsync_pin        (vsync_pin),
      .power_pin        (power_pin),
      .irRiseSel        (irRiseSel),
      .irEnable         (irEnable),
      .irClear          (irClear),
      .pwrRiseSel       (pwrRiseSel),
      .pwrEnable        (pwrEnable),
      .pwrClear         (pwrClear),
      .vsyncEnable      (vsyncEnable),
      .tmr1_flag        (tmr1_flag),
      .tmr1_mask        (tmr1_mask),
      .tmr2_flag        (tmr2_flag),
      .tmr2_mask        (tmr2_mask),
      .entry            (entry),
      .flagSet          (flagSet),
      .infraredLatch    (infraredLatch),
      .infrared_request (infrared_request),
      .power_request    (power_request)
   );
   fpi_core_model u_core (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .retiReq   (retiReq),
      .lastCycle (lastCycle),
      .retiExec  (retiExec)
   );

   // 10 MHz core clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : chk

   // Drives land 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step

   // Byte or single-bit write on the data space port
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b);
      dataAddr = a;
      dataWdata = d;
      bitOp = b;
      dataWrite = 1'b1;
      step(1);
      dataWrite = 1'b0;
      bitOp = 1'b0;
      // Let an edge pass so back-to-back writes never retoggle the strobe
      step(1);
   endtask : wr

   // Bounded wait for an entry, then check what it carries
   task automatic take(input logic [11:0] v, input logic [2:0] s);
      int n;
      n = 0;
      @(negedge clk_sys);
      while (entry.take !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      chk(entry.take === 1'b1 && entry.vector === v && entry.source === s, "entry");
      step(1);
   endtask : take

   // Several instructions must pass with no entry
   task automatic no_take();
      logic bad;
      bad = 1'b0;
      repeat (12) begin
         @(negedge clk_sys);
         if (entry.take !== 1'b0) bad = 1'b1;
      end
      chk(!bad, "unexpected entry");
      step(1);
   endtask : no_take

   // Return, optionally with a new entry in the same final cycle
   task automatic return_from_interrupt(input logic t, input logic [11:0] v, input logic [2:0] s,
                       input fpi_pkg::fpi_flagset_t fs);
      int n;
      n = 0;
      retiReq = 1'b1;
      @(negedge clk_sys);
      while (entry.popPc !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      chk(entry.popPc === 1'b1 && entry.take === t, "return");
      if (t) chk(entry.vector === v && entry.source === s, "return entry");
      step(1);
      retiReq = 1'b0;
      chk(flagSet === fs, "flag set");
   endtask : return_from_interrupt

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test

   // Watchdog: whole run is well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk_sys);
      err_total++;
      stop_test();
   end

   initial begin
      {dataWrite, bitOp, retiReq, irRiseSel, irEnable, irClear} = 6'h00;
      {pwrRiseSel, pwrEnable, pwrClear, vsyncEnable, power_pin} = 5'h00;
      {tmr1_flag, tmr1_mask, tmr2_flag, tmr2_mask} = 4'h0;
      {infrared_pin, vsync_pin} = 2'h3;
      dataAddr = 8'h00;
      dataWdata = 8'h00;
      err_total = 0;
      comparisons = 0;
      nrst = 1'b0;
      repeat (12) @(posedge clk_sys);
      #1 nrst = 1'b1;
      chk(flagSet === fpi_pkg::FS_NMI, "reset mode");
      chk(infrared_request === 1'b1 && power_request === 1'b1, "idle");
      chk(infraredLatch === 1'b0, "latch reset");
      wr(OPT, 8'h50, 1'b0);
      {tmr2_flag, tmr2_mask, tmr1_flag, tmr1_mask} = 4'hf;
      no_take();
      return_from_interrupt(1'b1, fpi_pkg::VEC1_ADDR, 3'h1, fpi_pkg::FS_IRQ);
      tmr2_flag = 1'b0;
      irEnable = 1'b1;
      no_take();
      infrared_pin = 1'b0;
      take(fpi_pkg::VEC0_ADDR, 3'h0);
      chk(flagSet === fpi_pkg::FS_NMI, "nmi mode");
      return_from_interrupt(1'b0, 12'h000, 3'h0, fpi_pkg::FS_IRQ);
      return_from_interrupt(1'b1, fpi_pkg::VEC3_ADDR, 3'h3, fpi_pkg::FS_IRQ);
      tmr1_flag = 1'b0;
      {pwrEnable, pwrRiseSel} = 2'h3;
      step(1);
      power_pin = 1'b1;
      step(3);
      chk(power_request === 1'b0, "power latch");
      return_from_interrupt(1'b1, fpi_pkg::VEC4_ADDR, 3'h4, fpi_pkg::FS_IRQ);
      pwrClear = 1'b1;
      {tmr1_flag, tmr1_mask} = 2'h2;
      step(1);
      pwrClear = 1'b0;
      step(1);
      chk(power_request === 1'b1, "power clear");
      return_from_interrupt(1'b0, 12'h000, 3'h0, fpi_pkg::FS_NORMAL);
      tmr1_flag = 1'b0;
      vsyncEnable = 1'b1;
      step(1);
      vsync_pin = 1'b0;
      take(fpi_pkg::VEC2_ADDR, 3'h2);
      return_from_interrupt(1'b0, 12'h000, 3'h0, fpi_pkg::FS_NORMAL);
      wr(OPT, 8'h70, 1'b0);
      wr(OPT, 8'h00, 1'b1);
      wr(8'hc9, 8'h00, 1'b0);
      vsync_pin = 1'b1;
      take(fpi_pkg::VEC2_ADDR, 3'h2);
      return_from_interrupt(1'b0, 12'h000, 3'h0, fpi_pkg::FS_NORMAL);
      wr(OPT, 8'h60, 1'b0);
      vsync_pin = 1'b0;
      step(1);
      vsync_pin = 1'b1;
      no_take();
      wr(OPT, 8'h70, 1'b0);
      take(fpi_pkg::VEC2_ADDR, 3'h2);
      return_from_interrupt(1'b0, 12'h000, 3'h0, fpi_pkg::FS_NORMAL);
      wr(OPT, 8'h60, 1'b0);
      irClear = 1'b1;
      step(1);
      irClear = 1'b0;
      step(1);
      chk(infraredLatch === 1'b0 && infrared_request === 1'b1, "ir clear");
      irRiseSel = 1'b1;
      step(1);
      infrared_pin = 1'b1;
      take(fpi_pkg::VEC0_ADDR, 3'h0);
      return_from_interrupt(1'b0, 12'h000, 3'h0, fpi_pkg::FS_NORMAL);
      stop_test();
   end
endmodule : test_fixed_priority_interrupt_unit
`default_nettype wire
